/* File: src/ebalu_core.sv */
`timescale 1ns/1ps
module ebalu_core
	import ebalu_pkg::*;
#(
	parameter int CLK_DIV = 1            // base core clock divider, doubled per step of the clock select
)
(
	input  wire logic        MCLK,
	input  wire logic        ARST_N,
	input  wire logic [2:0]  CLK_SEL,    // processor clock select field
	input  wire logic        REQ_VALID,
	input  wire ebalu_req_t  REQ,
	input  wire logic        MEM_WAIT,   // read or write wait from expansion area
	input  wire logic        PSW_LOAD,   // sequencer loads a new status word
	input  wire logic [7:0]  PSW_IN,
	output ebalu_rsp_t       RSP,
	output logic             DONE,
	output logic             BUSY,
	output logic [7:0]       PSW_OUT
);

	////////////////////////////////////////////////////////////////////////
	// core clock enable
	logic [7:0] div_ff;                  // prescaler count
	logic [7:0] div_lim;                 // divide ratio minus one
	logic       cpu_en;                  // one core clock cycle
	logic       start;                   // request taken at this edge

	assign div_lim = 8'((CLK_DIV << CLK_SEL) - 1);
	assign cpu_en  = div_ff >= div_lim;

	// prescaler; restarts on accept so the first core cycle is a whole one
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= (cpu_en || start) ? 8'h00 : div_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request latch
	ebalu_req_t req_ff;                  // operation in flight
	logic       cy;                      // current carry
	logic [7:0] psw_ff;                  // status word
	logic       busy_w;
	logic       last_w;

	assign cy    = psw_ff[EBALU_PSW_CY];
	assign start = REQ_VALID && !busy_w;

	// hold the request for the whole instruction
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			req_ff <= '0;
		end else if (start) begin
			req_ff <= REQ;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cycle figure
	logic [5:0] base;
	logic       slow;                    // operand outside fast RAM

	assign slow = REQ.ext || REQ.sfr;

	// per-operation cycle figure; long figure plus waits counted by timer
	always_comb begin
		unique case (REQ.op)
			EBALU_OP_WADD, EBALU_OP_WSUB, EBALU_OP_WCMP: base = EBALU_CYC_WORD;
			EBALU_OP_MUL:                                base = EBALU_CYC_MUL;
			EBALU_OP_DIV:                                base = EBALU_CYC_DIV;
			EBALU_OP_INC, EBALU_OP_DEC:                  base = slow ? EBALU_CYC_INCL : EBALU_CYC_INCR;
			EBALU_OP_PINC, EBALU_OP_PDEC:                base = EBALU_CYC_PAIR;
			EBALU_OP_ROR, EBALU_OP_ROL,
			EBALU_OP_RTCR, EBALU_OP_RTCL:                base = EBALU_CYC_ROT;
			EBALU_OP_NRR, EBALU_OP_NRL:                  base = slow ? EBALU_CYC_NIBX : EBALU_CYC_NIB;
			EBALU_OP_DAA, EBALU_OP_DAS:                  base = EBALU_CYC_ADJ;
			EBALU_OP_CAND, EBALU_OP_COR,
			EBALU_OP_CXOR, EBALU_OP_CMOV:                base = slow ? EBALU_CYC_CBITX : EBALU_CYC_CBIT;
			EBALU_OP_CSET, EBALU_OP_CCLR, EBALU_OP_CINV: base = EBALU_CYC_CFLAG;
			EBALU_OP_PSWBIT:                             base = EBALU_CYC_PSWB;
			EBALU_OP_NONE:                               base = EBALU_CYC_ROT;
			default:                                     base = slow ? EBALU_CYC_EXT : EBALU_CYC_BYTE;
		endcase
	end

	// instruction timer
	ebalu_cycles u_cycles (
		.clk      (MCLK),
		.arst_n   (ARST_N),
		.cpu_en   (cpu_en),
		.start    (start),
		.base     (base),
		.wait_req (MEM_WAIT && req_ff.ext),
		.busy     (busy_w),
		.last     (last_w)
	);

	////////////////////////////////////////////////////////////////////////
	// iterative divide (shift-subtract, one step per core cycle)
	logic [15:0] quo_ff;                 // dividend shifting into quotient
	logic [7:0]  rem_ff;                 // partial remainder
	logic [4:0]  step_ff;                // steps left
	logic [8:0]  trial;                  // remainder shifted with next bit
	logic [8:0]  diff9;

	assign trial = {rem_ff, quo_ff[15]};
	assign diff9 = trial - {1'b0, req_ff.src[7:0]};

	// quotient and remainder built in steps
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			quo_ff  <= 16'h0000;
			rem_ff  <= 8'h00;
			step_ff <= 5'h00;
		end else if (start) begin
			quo_ff  <= REQ.dst;
			rem_ff  <= 8'h00;
			step_ff <= 5'(EBALU_DIV_STEPS);
		end else if (cpu_en && step_ff != 5'h00) begin
			// borrow clear means divisor fits
			quo_ff  <= {quo_ff[14:0], !diff9[8]};
			rem_ff  <= diff9[8] ? trial[7:0] : diff9[7:0];
			step_ff <= step_ff - 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// datapath
	logic [7:0]  a;                      // destination byte
	logic [7:0]  b;                      // operand byte
	logic        sub_cin;                // borrow in for byte subtraction
	logic [8:0]  bdiff;                  // byte difference with borrow out
	logic [4:0]  hdiff;                  // low nibble difference with half borrow
	logic [16:0] wsum;                   // word add
	logic [16:0] wdiff;                  // word subtract
	logic [8:0]  inc9;
	logic [8:0]  dec9;
	logic        sel_bit;                // selected operand bit
	logic [7:0]  mem_b;                  // memory byte for nibble rotates
	logic        lo_adj;
	logic        hi_adj;
	logic [7:0]  daa_v;
	logic [8:0]  dad_sum;
	logic [7:0]  das_v;

	assign a       = req_ff.dst[7:0];
	assign b       = req_ff.src[7:0];
	assign mem_b   = req_ff.src[7:0];
	assign sub_cin = (req_ff.op == EBALU_OP_SUBB) ? cy : 1'b0;
	assign bdiff   = {1'b0, a} - {1'b0, b} - {8'h00, sub_cin};
	assign hdiff   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, sub_cin};
	// word arithmetic, carry from bit 15
	assign wsum    = {1'b0, req_ff.dst} + {1'b0, req_ff.src};
	assign wdiff   = {1'b0, req_ff.dst} - {1'b0, req_ff.src};
	assign inc9    = {1'b0, a} + 9'h001;
	assign dec9    = {1'b0, a} - 9'h001;
	assign sel_bit = b[req_ff.bit_sel];
	// decimal adjust uses half carry and carry of the prior op
	assign lo_adj  = psw_ff[EBALU_PSW_AC] || (a[3:0] > 4'h9);
	assign hi_adj  = cy || (a > 8'h99);
	assign dad_sum = {1'b0, a} + {1'b0, (hi_adj ? 8'h60 : 8'h00) | (lo_adj ? 8'h06 : 8'h00)};
	assign daa_v   = dad_sum[7:0];
	assign das_v   = a - ((psw_ff[EBALU_PSW_CY] ? 8'h60 : 8'h00) | (psw_ff[EBALU_PSW_AC] ? 8'h06 : 8'h00));

	ebalu_rsp_t rsp_n;                   // result of the current op
	logic [7:0] psw_n;                   // status word after the op

	// result and flag selection; untouched flags keep their value
	always_comb begin
		rsp_n = '0;
		psw_n = psw_ff;
		unique case (req_ff.op)
			EBALU_OP_SUB, EBALU_OP_SUBB: begin
				rsp_n.res = {8'h00, bdiff[7:0]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = bdiff[7:0] == 8'h00;
				psw_n[EBALU_PSW_AC] = hdiff[4];
				psw_n[EBALU_PSW_CY] = bdiff[8];
			end
			EBALU_OP_CMP: begin
				psw_n[EBALU_PSW_Z]  = bdiff[7:0] == 8'h00;
				psw_n[EBALU_PSW_AC] = hdiff[4];
				psw_n[EBALU_PSW_CY] = bdiff[8];
			end
			EBALU_OP_AND: begin
				rsp_n.res = {8'h00, a & b};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z] = (a & b) == 8'h00;
			end
			EBALU_OP_OR: begin
				rsp_n.res = {8'h00, a | b};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z] = (a | b) == 8'h00;
			end
			EBALU_OP_XOR: begin
				rsp_n.res = {8'h00, a ^ b};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z] = (a ^ b) == 8'h00;
			end
			// word add, half carry from bit 7
			EBALU_OP_WADD: begin
				rsp_n.res = wsum[15:0];
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = wsum[15:0] == 16'h0000;
				psw_n[EBALU_PSW_AC] = wsum[8] ^ req_ff.dst[8] ^ req_ff.src[8];
				psw_n[EBALU_PSW_CY] = wsum[16];
			end
			EBALU_OP_WSUB, EBALU_OP_WCMP: begin
				rsp_n.res = wdiff[15:0];
				rsp_n.wr_res = req_ff.op == EBALU_OP_WSUB;
				psw_n[EBALU_PSW_Z]  = wdiff[15:0] == 16'h0000;
				psw_n[EBALU_PSW_AC] = wdiff[8] ^ req_ff.dst[8] ^ req_ff.src[8];
				psw_n[EBALU_PSW_CY] = wdiff[16];
			end
			EBALU_OP_MUL: begin
				rsp_n.res = 16'(a * b);
				rsp_n.wr_res = 1'b1;
			end
			EBALU_OP_DIV: begin
				rsp_n.res = quo_ff;
				rsp_n.aux = rem_ff;
				rsp_n.wr_res = 1'b1;
				rsp_n.wr_aux = 1'b1;
			end
			EBALU_OP_INC: begin
				rsp_n.res = {8'h00, inc9[7:0]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = inc9[7:0] == 8'h00;
				psw_n[EBALU_PSW_AC] = a[3:0] == 4'hF;
			end
			EBALU_OP_DEC: begin
				rsp_n.res = {8'h00, dec9[7:0]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = dec9[7:0] == 8'h00;
				psw_n[EBALU_PSW_AC] = a[3:0] == 4'h0;
			end
			EBALU_OP_PINC, EBALU_OP_PDEC: begin
				rsp_n.res = (req_ff.op == EBALU_OP_PINC) ? req_ff.dst + 16'h0001 : req_ff.dst - 16'h0001;
				rsp_n.wr_res = 1'b1;
			end
			EBALU_OP_ROR: begin
				rsp_n.res = {8'h00, a[0], a[7:1]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_CY] = a[0];
			end
			EBALU_OP_ROL: begin
				rsp_n.res = {8'h00, a[6:0], a[7]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_CY] = a[7];
			end
			EBALU_OP_RTCR: begin
				rsp_n.res = {8'h00, cy, a[7:1]};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_CY] = a[0];
			end
			EBALU_OP_RTCL: begin
				rsp_n.res = {8'h00, a[6:0], cy};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_CY] = a[7];
			end
			// twelve-bit right rotate, memory byte in aux
			EBALU_OP_NRR: begin
				rsp_n.res = {8'h00, a[7:4], mem_b[3:0]};
				rsp_n.aux = {a[3:0], mem_b[7:4]};
				rsp_n.wr_res = 1'b1;
				rsp_n.wr_aux = 1'b1;
			end
			EBALU_OP_NRL: begin
				rsp_n.res = {8'h00, a[7:4], mem_b[7:4]};
				rsp_n.aux = {mem_b[3:0], a[3:0]};
				rsp_n.wr_res = 1'b1;
				rsp_n.wr_aux = 1'b1;
			end
			EBALU_OP_DAA: begin
				rsp_n.res = {8'h00, daa_v};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = daa_v == 8'h00;
				psw_n[EBALU_PSW_AC] = lo_adj && (a[3:0] > 4'h9);
				psw_n[EBALU_PSW_CY] = hi_adj || dad_sum[8];
			end
			EBALU_OP_DAS: begin
				rsp_n.res = {8'h00, das_v};
				rsp_n.wr_res = 1'b1;
				psw_n[EBALU_PSW_Z]  = das_v == 8'h00;
				psw_n[EBALU_PSW_AC] = 1'b0;
			end
			EBALU_OP_CAND: psw_n[EBALU_PSW_CY] = cy & sel_bit;
			EBALU_OP_COR:  psw_n[EBALU_PSW_CY] = cy | sel_bit;
			EBALU_OP_CXOR: psw_n[EBALU_PSW_CY] = cy ^ sel_bit;
			EBALU_OP_CMOV: psw_n[EBALU_PSW_CY] = sel_bit;
			EBALU_OP_CSET: psw_n[EBALU_PSW_CY] = 1'b1;
			EBALU_OP_CCLR: psw_n[EBALU_PSW_CY] = 1'b0;
			EBALU_OP_CINV: psw_n[EBALU_PSW_CY] = !cy;
			EBALU_OP_PSWBIT: psw_n[req_ff.bit_sel] = req_ff.bit_val;
			EBALU_OP_NONE: begin
				rsp_n = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// output registers
	ebalu_rsp_t rsp_ff;
	logic       done_ff;
	logic       busy_ff;

	// results land on the last core cycle
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rsp_ff  <= '0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			psw_ff  <= EBALU_PSW_RST;
		end else begin
			done_ff <= last_w;
			busy_ff <= start || (busy_w && !last_w);
			if (last_w) begin
				rsp_ff <= rsp_n;
				psw_ff <= psw_n;
			end else if (PSW_LOAD && !busy_w) begin
				psw_ff <= PSW_IN;
			end
		end
	end

	assign RSP     = rsp_ff;
	assign DONE    = done_ff;
	assign BUSY    = busy_ff;
	assign PSW_OUT = psw_ff;

endmodule

/* File: src/ebalu_cycles.sv */
`timescale 1ns/1ps
// instruction timer: counts core clock enables, stretched by wait states
module ebalu_cycles
	import ebalu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       cpu_en,     // one core clock cycle
	input  wire logic       start,      // load a new count
	input  wire logic [5:0] base,       // cycles from the short/long figure
	input  wire logic       wait_req,   // memory asks for one more cycle
	output logic            busy,
	output logic            last        // final enabled cycle
);
	logic [5:0] cnt_ff;                 // cycles still to run
	logic [5:0] nxt_cnt;

	// a wait cycle holds the count, so n and m add one each
	assign nxt_cnt = start ? base :
	                 (cpu_en && !wait_req && cnt_ff != 6'h00) ? cnt_ff - 6'h01 : cnt_ff;
	assign busy    = cnt_ff != 6'h00;
	assign last    = cpu_en && !wait_req && cnt_ff == 6'h01;

	// counter register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 6'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

/* File: src/ebalu_pkg.sv */
package ebalu_pkg;

	// operation codes presented by the sequencer
	typedef enum logic [4:0] {
		EBALU_OP_NONE    = 5'h00,
		EBALU_OP_SUB     = 5'h01,
		EBALU_OP_SUBB    = 5'h02,
		EBALU_OP_AND     = 5'h03,
		EBALU_OP_OR      = 5'h04,
		EBALU_OP_XOR     = 5'h05,
		EBALU_OP_CMP     = 5'h06,
		EBALU_OP_WADD    = 5'h07,
		EBALU_OP_WSUB    = 5'h08,
		EBALU_OP_WCMP    = 5'h09,
		EBALU_OP_MUL     = 5'h0A,
		EBALU_OP_DIV     = 5'h0B,
		EBALU_OP_INC     = 5'h0C,
		EBALU_OP_DEC     = 5'h0D,
		EBALU_OP_PINC    = 5'h0E,
		EBALU_OP_PDEC    = 5'h0F,
		EBALU_OP_ROR     = 5'h10,
		EBALU_OP_ROL     = 5'h11,
		EBALU_OP_RTCR    = 5'h12,
		EBALU_OP_RTCL    = 5'h13,
		EBALU_OP_NRR     = 5'h14,
		EBALU_OP_NRL     = 5'h15,
		EBALU_OP_DAA     = 5'h16,
		EBALU_OP_DAS     = 5'h17,
		EBALU_OP_CAND    = 5'h18,
		EBALU_OP_COR     = 5'h19,
		EBALU_OP_CXOR    = 5'h1A,
		EBALU_OP_CMOV    = 5'h1B,
		EBALU_OP_CSET    = 5'h1C,
		EBALU_OP_CCLR    = 5'h1D,
		EBALU_OP_CINV    = 5'h1E,
		EBALU_OP_PSWBIT  = 5'h1F
	} ebalu_op_t;

	// request from the sequencer
	typedef struct packed {
		ebalu_op_t  op;        // operation
		logic [15:0] dst;      // destination byte/word (accumulator pair for word ops)
		logic [15:0] src;      // operand byte/word, divisor in low byte
		logic [2:0]  bit_sel;  // bit index for carry logic / status bit ops
		logic        bit_val;  // value written by status bit ops
		logic        ext;      // operand in the external expansion area
		logic        sfr;      // operand is a special function register
		logic        rmw;      // form reads then writes memory
	} ebalu_req_t;

	// result back to the sequencer
	typedef struct packed {
		logic [15:0] res;      // main result (pair or byte in low bits)
		logic [7:0]  aux;      // remainder or rewritten memory byte
		logic        wr_res;   // result must be written back
		logic        wr_aux;   // aux must be written back
	} ebalu_rsp_t;

	// status word bit positions
	localparam int EBALU_PSW_CY = 0;
	localparam int EBALU_PSW_AC = 4;
	localparam int EBALU_PSW_Z  = 6;
	localparam logic [7:0] EBALU_PSW_RST = 8'h02;

	// cycle counts, short and long figures
	localparam logic [5:0] EBALU_CYC_BYTE    = 6'h04;
	localparam logic [5:0] EBALU_CYC_EXT     = 6'h09;
	localparam logic [5:0] EBALU_CYC_WORD    = 6'h06;
	localparam logic [5:0] EBALU_CYC_MUL     = 6'h10;
	localparam logic [5:0] EBALU_CYC_DIV     = 6'h19;
	localparam logic [5:0] EBALU_CYC_INCR    = 6'h02;
	localparam logic [5:0] EBALU_CYC_INCM    = 6'h04;
	localparam logic [5:0] EBALU_CYC_INCL    = 6'h06;
	localparam logic [5:0] EBALU_CYC_PAIR    = 6'h04;
	localparam logic [5:0] EBALU_CYC_ROT     = 6'h02;
	localparam logic [5:0] EBALU_CYC_NIB     = 6'h0A;
	localparam logic [5:0] EBALU_CYC_NIBX    = 6'h0C;
	localparam logic [5:0] EBALU_CYC_ADJ     = 6'h04;
	localparam logic [5:0] EBALU_CYC_CBIT    = 6'h06;
	localparam logic [5:0] EBALU_CYC_CBITX   = 6'h07;
	localparam logic [5:0] EBALU_CYC_PSWB    = 6'h06;
	localparam logic [5:0] EBALU_CYC_CFLAG   = 6'h02;
	localparam int         EBALU_DIV_STEPS   = 16;

endpackage

/* File: testbench/ebalu_core_chk.sv */
`timescale 1ns/1ps
// judges finished byte, multiply, divide, rotate-right, carry force and pair step operations against the request it took
module ebalu_core_chk
	import ebalu_pkg::*;
#(
	parameter int CLK_DIV = 1
)
(
	input wire logic       MCLK,
	input wire logic       ARST_N,
	input wire logic [2:0] CLK_SEL,
	input wire logic       REQ_VALID,
	input wire ebalu_req_t REQ,
	input wire ebalu_rsp_t RSP,
	input wire logic       DONE,
	input wire logic       BUSY,
	input wire logic [7:0] PSW_OUT
);
	ebalu_req_t q_ff;   // request in flight
	logic [7:0] h_ff;   // status word before it
	logic [5:0] n_ff;   // cycles since accept
	logic [2:0] sel_ff; // clock select held at accept
	wire        acc = REQ_VALID && (!BUSY || DONE);
	wire [7:0]  d = q_ff.dst[7:0];
	wire [7:0]  s = q_ff.src[7:0];
	wire        plain = !q_ff.ext && !q_ff.sfr && sel_ff <= 3'h1 && CLK_DIV == 1;
	// short figures only; two-figure forms other than the byte ops are skipped
	function automatic logic [5:0] base(input ebalu_op_t op);
		case (op)
			EBALU_OP_SUB, EBALU_OP_SUBB, EBALU_OP_AND, EBALU_OP_OR, EBALU_OP_XOR, EBALU_OP_CMP: base = 6'h04;
			EBALU_OP_WADD, EBALU_OP_WSUB, EBALU_OP_WCMP: base = 6'h06;
			EBALU_OP_MUL: base = 6'h10;
			EBALU_OP_DIV: base = 6'h19;
			EBALU_OP_PINC, EBALU_OP_PDEC, EBALU_OP_DAA, EBALU_OP_DAS: base = 6'h04;
			EBALU_OP_ROR, EBALU_OP_ROL, EBALU_OP_RTCR, EBALU_OP_RTCL: base = 6'h02;
			EBALU_OP_CSET, EBALU_OP_CCLR, EBALU_OP_CINV: base = 6'h02;
			default: base = 6'h00;
		endcase
	endfunction
	// capture request and counter
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			q_ff <= '0;
			h_ff <= 8'h00;
			n_ff <= 6'h00;
			sel_ff <= 3'h0;
		end else begin
			sel_ff <= acc ? CLK_SEL : sel_ff;
			q_ff <= acc ? REQ : q_ff;
			h_ff <= acc ? PSW_OUT : h_ff;
			n_ff <= acc ? 6'h01 : n_ff + {5'h00, n_ff != 6'h3F};
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	////////////////////////////////////////////////////////////////
	chk_sub_diff: assert property (DONE && q_ff.op == EBALU_OP_SUB |-> RSP.res[7:0] == d - s
		&& PSW_OUT[0] == (d < s) && PSW_OUT[6] == (d == s)) else $error("subtract wrong");
	chk_subb_borrow: assert property (DONE && q_ff.op == EBALU_OP_SUBB |->
		RSP.res[7:0] == d - s - h_ff[0] && PSW_OUT[0] == ({1'b0, d} < {1'b0, s} + h_ff[0])) else $error("borrow wrong");
	chk_logic_flags: assert property (DONE && q_ff.op inside {EBALU_OP_AND, EBALU_OP_OR, EBALU_OP_XOR} |->
		RSP.res[7:0] == (q_ff.op == EBALU_OP_AND ? d & s : q_ff.op == EBALU_OP_OR ? d | s : d ^ s)
		&& {PSW_OUT[4], PSW_OUT[0]} == {h_ff[4], h_ff[0]} && PSW_OUT[6] == (RSP.res[7:0] == 8'h00))
		else $error("logic op wrong");
	chk_cmp_nowrite: assert property (DONE && q_ff.op == EBALU_OP_CMP |-> !RSP.wr_res && !RSP.wr_aux
		&& PSW_OUT[0] == (d < s)) else $error("compare wrote");
	chk_mul_product: assert property (DONE && q_ff.op == EBALU_OP_MUL |-> RSP.res == d * s && PSW_OUT == h_ff)
		else $error("product wrong");
	chk_div_quot: assert property (DONE && q_ff.op == EBALU_OP_DIV && s != 8'h00 |-> RSP.res == q_ff.dst / s
		&& RSP.aux == q_ff.dst % s && PSW_OUT == h_ff) else $error("divide wrong");
	chk_cycle_count: assert property (DONE && plain && base(q_ff.op) != 6'h00 |->
		n_ff == (base(q_ff.op) << sel_ff) + 6'h01)
		else $error("cycle count wrong");
	chk_rotate_two: assert property (acc && REQ.op == EBALU_OP_ROR && !REQ.ext && CLK_SEL == 3'h0 && CLK_DIV == 1
		|=> !DONE [*2] ##1 DONE) else $error("rotate time wrong");
	chk_rotate_wrap: assert property (DONE && q_ff.op == EBALU_OP_ROR |-> RSP.res[7:0] == {d[0], d[7:1]}
		&& PSW_OUT == {h_ff[7:1], d[0]}) else $error("rotate wrong");
	chk_carry_force: assert property (DONE && q_ff.op inside {EBALU_OP_CSET, EBALU_OP_CCLR, EBALU_OP_CINV} |->
		PSW_OUT == {h_ff[7:1], q_ff.op == EBALU_OP_CSET || (q_ff.op == EBALU_OP_CINV && !h_ff[0])})
		else $error("carry force wrong");
	chk_pair_step: assert property (DONE && q_ff.op inside {EBALU_OP_PINC, EBALU_OP_PDEC} |-> PSW_OUT == h_ff
		&& RSP.res == q_ff.dst + (q_ff.op == EBALU_OP_PINC ? 16'h0001 : 16'hFFFF)) else $error("pair step wrong");
	cov_div: cover property (DONE && q_ff.op == EBALU_OP_DIV);
	cov_ext: cover property (acc && REQ.ext);
	cov_back: cover property (acc && DONE);
endmodule
bind ebalu_core ebalu_core_chk #(.CLK_DIV(CLK_DIV)) u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .CLK_SEL(CLK_SEL),
	.REQ_VALID(REQ_VALID), .REQ(REQ), .RSP(RSP), .DONE(DONE), .BUSY(BUSY), .PSW_OUT(PSW_OUT));

/* File: testbench/ebalu_core_test.sv */
`timescale 1ns/1ps
// self-checking bench for the execution datapath
module ebalu_core_test
	import ebalu_pkg::*;
;
	logic       mclk;      // core input clock
	logic       arst_n;    // reset, active low
	logic [2:0] clk_sel;   // core clock select
	logic       rv;        // request strobe
	ebalu_req_t req;       // request
	logic       pl;        // status load
	logic [7:0] pi;        // status value
	logic [3:0] waits;     // far side waits
	logic       mem_wait;  // from far side
	ebalu_rsp_t rsp;       // result
	logic       done;      // end pulse
	logic       busy;      // running
	logic [7:0] program_status_word;       // status word
	int         fail_count;
	int         n_tests;
	int         n;         // cycles of last operation
	ebalu_core #(.CLK_DIV(1)) uut (.MCLK(mclk), .ARST_N(arst_n), .CLK_SEL(clk_sel), .REQ_VALID(rv), .REQ(req),
		.MEM_WAIT(mem_wait), .PSW_LOAD(pl), .PSW_IN(pi), .RSP(rsp), .DONE(done), .BUSY(busy), .PSW_OUT(program_status_word));
	ebalu_seq_model far (.mclk(mclk), .arst_n(arst_n), .busy(busy), .waits(waits), .mem_wait(mem_wait));
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		n_tests++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	// issue at a falling edge, wait for the end; poke adds a refused request and load
	task automatic run(input ebalu_op_t op, input logic [15:0] d, input logic [15:0] s, input logic poke);
		req.op = op;
		req.dst = d;
		req.src = s;
		rv = 1'b1;
		n = 0;
		@(negedge mclk);
		check(busy, 1'b1);
		while (done !== 1'b1 && n < 200) begin
			rv = poke && n == 3;
			pl = rv;
			@(negedge mclk);
			n++;
		end
	endtask
	// load the status word while idle
	task automatic load(input logic [7:0] v);
		@(negedge mclk);
		pl = 1'b1;
		pi = v;
		@(negedge mclk);
		pl = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// subtract, back to back, then compare
	task automatic t_sub();
		load(8'h00);
		run(EBALU_OP_SUB, 16'h0010, 16'h0020, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51, n[5:0]}, {8'hF0, 8'h01, 6'h04});
		run(EBALU_OP_SUB, 16'h0033, 16'h0033, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51}, 16'h0040);
		load(8'h01);
		run(EBALU_OP_SUBB, 16'h0010, 16'h000F, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51}, 16'h0050);
		run(EBALU_OP_SUBB, 16'h0000, 16'h0001, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51}, 16'hFF11);
		run(EBALU_OP_CMP, 16'h0005, 16'h0006, 1'b0);
		check({rsp.wr_res, rsp.wr_aux, program_status_word & 8'h51}, 10'h011);
	endtask
	// logic ops keep carry and half carry
	task automatic t_logic();
		ebalu_op_t  ops [4] = '{EBALU_OP_AND, EBALU_OP_OR, EBALU_OP_XOR, EBALU_OP_AND};
		logic [7:0] src [4] = '{8'h3C, 8'h3C, 8'h3C, 8'h0F};
		logic [7:0] want [4] = '{8'h30, 8'hFC, 8'hCC, 8'h00};
		load(8'h11);
		for (int i = 0; i < 4; i++) begin
			run(ops[i], 16'h00F0, {8'h00, src[i]}, 1'b0);
			check({rsp.res[7:0], rsp.wr_res, program_status_word}, {want[i], 1'b1, want[i] == 8'h00 ? 8'h51 : 8'h11});
		end
	endtask
	// word ops, multiply with refused request, divide
	task automatic t_word();
		int k;
		load(8'h00);
		run(EBALU_OP_WADD, 16'h00FF, 16'h0001, 1'b0);
		check({rsp.res, program_status_word & 8'h51, n[5:0]}, {16'h0100, 8'h10, 6'h06});
		run(EBALU_OP_WSUB, 16'h0000, 16'h0001, 1'b0);
		check({rsp.res, program_status_word & 8'h51}, {16'hFFFF, 8'h11});
		run(EBALU_OP_WCMP, 16'h1234, 16'h1234, 1'b0);
		check({rsp.wr_res, program_status_word & 8'h51, n[5:0]}, {1'b0, 8'h40, 6'h06});
		load(8'h51);
		pi = 8'hAA;
		run(EBALU_OP_MUL, 16'h00FF, 16'h00FF, 1'b1);
		check({rsp.res, program_status_word, n[5:0]}, {16'hFE01, 8'h51, 6'h10});
		k = 0;
		repeat (40) begin
			@(negedge mclk);
			k += int'(done === 1'b1);
		end
		check(k, 0);
		run(EBALU_OP_DIV, 16'hFFFF, 16'h0010, 1'b0);
		check({rsp.res, rsp.aux, program_status_word, n[5:0]}, {16'h0FFF, 8'h0F, 8'h51, 6'h19});
	endtask
	// increments: byte keeps carry, pair keeps all
	task automatic t_incdec();
		load(8'h01);
		run(EBALU_OP_INC, 16'h00FF, 16'h0000, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51}, 16'h0051);
		run(EBALU_OP_DEC, 16'h0000, 16'h0000, 1'b0);
		check({rsp.res[7:0], program_status_word & 8'h51}, 16'hFF11);
		run(EBALU_OP_PINC, 16'hFFFF, 16'h0000, 1'b0);
		check({rsp.res, program_status_word, n[5:0]}, {16'h0000, 8'h11, 6'h04});
		run(EBALU_OP_PDEC, 16'h0000, 16'h0000, 1'b0);
		check({rsp.res, program_status_word}, {16'hFFFF, 8'h11});
	endtask
	// rotates chained through carry
	task automatic t_rotate();
		ebalu_op_t  ops [4] = '{EBALU_OP_ROR, EBALU_OP_ROL, EBALU_OP_RTCR, EBALU_OP_RTCL};
		logic [7:0] din [4] = '{8'h01, 8'h80, 8'h02, 8'h80};
		logic [7:0] want [4] = '{8'h80, 8'h01, 8'h81, 8'h00};
		logic [3:0] cy = 4'b1011;
		load(8'h00);
		for (int i = 0; i < 4; i++) begin
			run(ops[i], {8'h00, din[i]}, 16'h0000, 1'b0);
			check({rsp.res[7:0], program_status_word, n[5:0]}, {want[i], 7'h00, cy[i], 6'h02});
		end
	endtask
	// nibble rotates and decimal adjust
	task automatic t_nibble();
		run(EBALU_OP_NRR, 16'h0012, 16'h0034, 1'b0);
		check({rsp.res[7:0], rsp.aux, rsp.wr_aux, n[5:0]}, {8'h14, 8'h23, 1'b1, 6'h0A});
		run(EBALU_OP_NRL, 16'h0012, 16'h0034, 1'b0);
		check({rsp.res[7:0], rsp.aux}, 16'h1342);
		load(8'h10);
		run(EBALU_OP_DAA, 16'h0041, 16'h0000, 1'b0);
		check({rsp.res[7:0], program_status_word[0], n[5:0]}, {8'h47, 1'b0, 6'h04});
		load(8'h10);
		run(EBALU_OP_DAS, 16'h002D, 16'h0000, 1'b0);
		check({rsp.res[7:0], program_status_word[0], n[5:0]}, {8'h27, 1'b0, 6'h04});
	endtask
	// carry bit logic, carry force, status bits
	task automatic t_bits();
		ebalu_op_t  ops [10] = '{EBALU_OP_CAND, EBALU_OP_CAND, EBALU_OP_COR, EBALU_OP_CXOR, EBALU_OP_CMOV,
			EBALU_OP_CSET, EBALU_OP_CCLR, EBALU_OP_CINV, EBALU_OP_PSWBIT, EBALU_OP_PSWBIT};
		logic [2:0] sel [10] = '{3'h3, 3'h2, 3'h3, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0};
		logic [7:0] want [10] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h41, 8'h40};
		load(8'h01);
		for (int i = 0; i < 10; i++) begin
			req.bit_sel = sel[i];
			req.bit_val = i == 8;
			run(ops[i], 16'h0000, 16'h0008, 1'b0);
			check(program_status_word, want[i]);
		end
	endtask
	// expansion area waits and a slower core clock
	task automatic t_timing();
		req.ext = 1'b1;
		run(EBALU_OP_SUB, 16'h0009, 16'h0001, 1'b0);
		check({rsp.res[7:0], n[5:0]}, {8'h08, 6'h09});
		waits = 4'h3;
		run(EBALU_OP_SUB, 16'h0009, 16'h0001, 1'b0);
		check(n, 12);
		waits = 4'h0;
		req.ext = 1'b0;
		req.sfr = 1'b1;
		run(EBALU_OP_INC, 16'h0041, 16'h0000, 1'b0);
		check({rsp.res[7:0], n[5:0]}, {8'h42, 6'h06});
		req.sfr = 1'b0;
		clk_sel = 3'h1;
		run(EBALU_OP_ROR, 16'h0002, 16'h0000, 1'b0);
		check({rsp.res[7:0], n[5:0]}, {8'h01, 6'h04});
		clk_sel = 3'h0;
	endtask
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// watchdog well past the expected run
	initial begin
		#40000;
		fail_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		arst_n = 1'b0;
		clk_sel = 3'h0;
		rv = 1'b0;
		req = '0;
		pl = 1'b0;
		pi = 8'h00;
		waits = 4'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		check({rsp, done, busy, program_status_word}, 40'h02);
		t_sub();
		t_logic();
		t_word();
		t_incdec();
		t_rotate();
		t_nibble();
		t_bits();
		t_timing();
		tally_and_finish();
	end
endmodule

/* File: testbench/ebalu_seq_model.sv */
`timescale 1ns/1ps
// far side: memory logic that stretches expansion-area accesses
module ebalu_seq_model
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       busy,     // datapath running
	input  wire logic [3:0] waits,    // waits to insert
	output logic            mem_wait  // one extra cycle per high cycle
);
	logic [3:0] cnt_ff;   // busy cycles seen
	logic [3:0] nxt_cnt;  // saturates so a long run never wraps into new waits
	assign nxt_cnt = !busy ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hF};
	// count busy cycles
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 4'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign mem_wait = busy && (cnt_ff < waits);
endmodule
